// ---- rtl/ssfs_pkg.sv ----
/*
 Package for the supply and fail mode supervisor: timing counts, field
 positions and mode encodings. Assumes a 100 MHz system clock.
*/
// Functional notes
// - Device operates only while wake is high, otherwise stays in Sleep.
// - Awake, reset pin low, not woken by reset pin: drive clock pin high.
// - Asleep or woken by reset pin: clock pin is input, not driven.
// - Power supply and logic supply both below reset: power off, clear all.
// - Power supply lost, logic supply present: keep state, channels off.
// - Power supply lost, logic supply present: external switch follows SPI.
// - Wake-up during power supply loss is not shown on clock pin.
// - Logic supply lost with power supply present: watchdog-timeout state.
// - Logic supply lost with power supply low: power off, clear all.
// - Ground loss turns off all five power channels.
// - SPI registers are readable only with logic supply present.
// - Normal mode: channels driven by PWM from SPI settings.
// - Report open load, short, severe short, OC, OT, clock, UV, OV faults.
// - Fail mode entered when fail-mode input is one.
// - Fail mode: channels 0 to 3 follow the four direct inputs; channel 4 is off.
// - Fail mode works without logic supply; controller may force it.
// - Fail-mode input level readable as status bit in status register 7.
// - Fail mode entered only after input high longer than 200 us.
package ssfs_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int DEGLITCH_US = 200;
   localparam int DEGLITCH_CYCLES = DEGLITCH_US * 1000 / CLK_PERIOD_NS;
   localparam int NUM_CHANNELS = 5;
   localparam int NUM_DIRECT = 4;
   localparam int NUM_FAULTS = 8;
   // Fault vector bit positions
   localparam int FLT_OPEN_LOAD = 0;
   localparam int FLT_SHORT_SUPPLY = 1;
   localparam int FLT_SEVERE_SHORT = 2;
   localparam int FLT_OVERCURRENT = 3;
   localparam int FLT_OVERTEMP = 4;
   localparam int FLT_CLOCK_FAIL = 5;
   localparam int FLT_UNDERVOLT = 6;
   localparam int FLT_OVERVOLT = 7;
   // Status register 7 layout
   localparam int STAT7_FAIL_INPUT_BIT = 0;
   localparam int STAT7_WIDTH = 8;
   typedef enum logic [1:0] {
      SSFS_OFF,
      SSFS_SLEEP,
      SSFS_NORMAL,
      SSFS_FAIL
   } ssfs_mode_t;
endpackage : ssfs_pkg

// ---- rtl/ssfs_supervisor.sv ----
/*
 Supply and fail mode supervisor. Selects Sleep, Normal or Fail mode,
 gates outputs on supply and ground loss, reports wake on the clock pin.
 Assumes supply-good levels come from analog comparators already clean,
 and that the PWM, SPI and fault detectors live outside this block.
*/
`timescale 1ns/1ps
module ssfs_supervisor
   import ssfs_pkg::*;
#(
   parameter int DEGLITCH_COUNT = DEGLITCH_CYCLES
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Supplies and wake
   input wire logic wake_in,
   input wire logic power_supply_ok_in,
   input wire logic logic_supply_ok_in,
   input wire logic ground_ok_in,
   // Controller pins
   input wire logic active_low_reset_pin_in,
   input wire logic fail_mode_pin_in,
   input wire logic [NUM_DIRECT-1:0] direct_channel_inputs_in,
   input wire logic clk_pin_in,
   // Internal sources
   input wire logic [NUM_CHANNELS-1:0] pwm_channels_in,
   input wire logic spi_ext_switch_in,
   input wire logic [NUM_FAULTS-1:0] fault_events_in,
   input wire logic fault_clear_in,
   // Outputs
   output logic [NUM_CHANNELS-1:0] power_channel_outputs_out,
   output logic external_switch_control_out,
   output logic clk_pin_out,
   output logic clk_pin_oe_n_out,
   output logic clk_pin_sampled_out,
   output logic spi_read_enable_out,
   output logic spi_watchdog_timeout_out,
   output logic registers_clear_out,
   output logic [NUM_FAULTS-1:0] fault_report_out,
   output logic [STAT7_WIDTH-1:0] status7_out,
   output logic fail_mode_out,
   output logic sleep_mode_out
);

   // ==========================================================
   // Input synchronisers
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [NUM_DIRECT-1:0] dir_a;
   logic [NUM_DIRECT-1:0] dir_b;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
         dir_a <= '0;
         dir_b <= '0;
      end else begin
         sync_a <= {active_low_reset_pin_in, fail_mode_pin_in, clk_pin_in};
         sync_b <= sync_a;
         dir_a <= direct_channel_inputs_in;
         dir_b <= dir_a;
      end
   end
   wire rst_pin_s = sync_b[2];
   wire fail_pin_s = sync_b[1];
   wire clk_pin_s = sync_b[0];

   // ==========================================================
   // Fail-mode deglitch
   logic [31:0] dgl_cnt;
   logic fail_filt;
   wire dgl_done = (dgl_cnt >= 32'(DEGLITCH_COUNT));
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dgl_cnt <= 32'h0;
         fail_filt <= 1'b0;
      end else begin
         if (!fail_pin_s) begin
            dgl_cnt <= 32'h0;
         end else if (!dgl_done) begin
            dgl_cnt <= dgl_cnt + 32'h1;
         end
         fail_filt <= fail_pin_s && dgl_done;
      end
   end

   // ==========================================================
   // Supply conditions
   wire power_off = !power_supply_ok_in && !logic_supply_ok_in;
   wire pwr_loss = !power_supply_ok_in && logic_supply_ok_in;
   wire vcc_loss = power_supply_ok_in && !logic_supply_ok_in;

   // ==========================================================
   // Mode state
   ssfs_mode_t mode;
   ssfs_mode_t next_mode;
   logic woke_by_reset;
   always_comb begin
      next_mode = mode;
      case (mode)
         SSFS_OFF: next_mode = power_off ? SSFS_OFF : SSFS_SLEEP;
         SSFS_SLEEP: next_mode = wake_in ?
            (fail_filt ? SSFS_FAIL : SSFS_NORMAL) : SSFS_SLEEP;
         SSFS_NORMAL: next_mode = fail_filt ? SSFS_FAIL : SSFS_NORMAL;
         SSFS_FAIL: next_mode = fail_filt ? SSFS_FAIL : SSFS_NORMAL;
         default: next_mode = SSFS_OFF;
      endcase
      if (power_off) begin
         next_mode = SSFS_OFF;
      end else if (!wake_in) begin
         next_mode = SSFS_SLEEP;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mode <= SSFS_OFF;
         woke_by_reset <= 1'b0;
      end else begin
         mode <= next_mode;
         // Remember the wake source when leaving sleep
         if (mode == SSFS_SLEEP && next_mode != SSFS_SLEEP) begin
            woke_by_reset <= rst_pin_s;
         end else if (next_mode == SSFS_SLEEP || next_mode == SSFS_OFF) begin
            woke_by_reset <= 1'b0;
         end
      end
   end

   wire awake = (mode == SSFS_NORMAL) || (mode == SSFS_FAIL);

   // ==========================================================
   // Fault latch: set wins over clear, power-off clears everything
   logic [NUM_FAULTS-1:0] faults;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         faults <= '0;
      end else if (power_off) begin
         faults <= '0;
      end else begin
         faults <= (fault_clear_in ? '0 : faults) | fault_events_in;
      end
   end

   // ==========================================================
   // Output selection
   wire [NUM_CHANNELS-1:0] direct_ext =
      {{(NUM_CHANNELS-NUM_DIRECT){1'b0}}, dir_b};
   wire [NUM_CHANNELS-1:0] chan_src =
      (mode == SSFS_FAIL) ? direct_ext : pwm_channels_in;
   wire chan_en = awake && power_supply_ok_in && ground_ok_in;
   wire report_wake = awake && !rst_pin_s && !woke_by_reset
      && power_supply_ok_in;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         power_channel_outputs_out <= '0;
         external_switch_control_out <= 1'b0;
         clk_pin_out <= 1'b0;
         clk_pin_oe_n_out <= 1'b1;
         clk_pin_sampled_out <= 1'b0;
         spi_read_enable_out <= 1'b0;
         spi_watchdog_timeout_out <= 1'b0;
         fault_report_out <= '0;
         status7_out <= '0;
      end else begin
         power_channel_outputs_out <= chan_en ? chan_src : '0;
         external_switch_control_out <= logic_supply_ok_in && ground_ok_in
            && (mode == SSFS_NORMAL || pwr_loss) && !power_off
            && spi_ext_switch_in;
         clk_pin_out <= report_wake;
         clk_pin_oe_n_out <= !report_wake;
         clk_pin_sampled_out <= clk_pin_s;
         spi_read_enable_out <= logic_supply_ok_in;
         spi_watchdog_timeout_out <= vcc_loss;
         fault_report_out <= logic_supply_ok_in ? faults : '0;
         status7_out <= logic_supply_ok_in ?
            STAT7_WIDTH'(fail_pin_s) << STAT7_FAIL_INPUT_BIT : '0;
      end
   end

   assign registers_clear_out = power_off;
   assign fail_mode_out = (mode == SSFS_FAIL);
   assign sleep_mode_out = (mode == SSFS_SLEEP) || (mode == SSFS_OFF);

   // ==========================================================
   // Assertions
   property p_sleep_outputs_off;
      @(posedge clk_in) disable iff (!reset_n_in)
      (!wake_in && mode != SSFS_NORMAL && mode != SSFS_FAIL)
         |=> (power_channel_outputs_out == '0);
   endproperty
   a_sleep_outputs_off: assert property (p_sleep_outputs_off)
      else $error("Channels on while asleep");

   property p_wake_report;
      @(posedge clk_in) disable iff (!reset_n_in)
      (awake && !rst_pin_s && !woke_by_reset && power_supply_ok_in)
         |=> (clk_pin_out && !clk_pin_oe_n_out);
   endproperty
   a_wake_report: assert property (p_wake_report)
      else $error("Wake state not reported on clock pin");

   property p_clk_input;
      @(posedge clk_in) disable iff (!reset_n_in)
      (!awake || woke_by_reset) |=> clk_pin_oe_n_out;
   endproperty
   a_clk_input: assert property (p_clk_input)
      else $error("Clock pin driven while asleep or reset-woken");

   property p_power_off;
      @(posedge clk_in) disable iff (!reset_n_in)
      (!power_supply_ok_in && !logic_supply_ok_in)
         |=> (power_channel_outputs_out == '0 && faults == '0
              && !external_switch_control_out);
   endproperty
   a_power_off: assert property (p_power_off)
      else $error("Power-off did not clear outputs and faults");

   property p_pwr_loss_channels;
      @(posedge clk_in) disable iff (!reset_n_in)
      !power_supply_ok_in |=> (power_channel_outputs_out == '0);
   endproperty
   a_pwr_loss_channels: assert property (p_pwr_loss_channels)
      else $error("Channels on during power supply loss");

   property p_ext_follows;
      @(posedge clk_in) disable iff (!reset_n_in)
      (pwr_loss && ground_ok_in)
         |=> (external_switch_control_out == $past(spi_ext_switch_in));
   endproperty
   a_ext_follows: assert property (p_ext_follows)
      else $error("External switch not following SPI during supply loss");

   property p_no_wake_report;
      @(posedge clk_in) disable iff (!reset_n_in)
      !power_supply_ok_in |=> !clk_pin_out;
   endproperty
   a_no_wake_report: assert property (p_no_wake_report)
      else $error("Wake reported during power supply loss");

   property p_wd_timeout;
      @(posedge clk_in) disable iff (!reset_n_in)
      (power_supply_ok_in && !logic_supply_ok_in)
         |=> spi_watchdog_timeout_out;
   endproperty
   a_wd_timeout: assert property (p_wd_timeout)
      else $error("Watchdog timeout missing on logic supply loss");

   property p_ground_loss;
      @(posedge clk_in) disable iff (!reset_n_in)
      !ground_ok_in |=> (power_channel_outputs_out == '0);
   endproperty
   a_ground_loss: assert property (p_ground_loss)
      else $error("Channels on during ground loss");

   property p_spi_read;
      @(posedge clk_in) disable iff (!reset_n_in)
      !logic_supply_ok_in |=> (!spi_read_enable_out && status7_out == '0);
   endproperty
   a_spi_read: assert property (p_spi_read)
      else $error("SPI readable without logic supply");

   property p_fail_follow;
      @(posedge clk_in) disable iff (!reset_n_in)
      (mode == SSFS_FAIL && power_supply_ok_in && ground_ok_in)
         |=> (power_channel_outputs_out[NUM_DIRECT-1:0] == $past(dir_b));
   endproperty
   a_fail_follow: assert property (p_fail_follow)
      else $error("Channel not following direct input in Fail mode");

   property p_deglitch;
      @(posedge clk_in) disable iff (!reset_n_in)
      $rose(fail_pin_s) |=> !fail_filt [*2];
   endproperty
   a_deglitch: assert property (p_deglitch)
      else $error("Fail mode entered before deglitch time");

   // Independent run length of the synced fail pin, so the deglitch
   // check below does not lean on the counter that it guards
   logic [31:0] fail_hi_run;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fail_hi_run <= 32'h0;
      end else if (!fail_pin_s) begin
         fail_hi_run <= 32'h0;
      end else if (fail_hi_run != 32'hFFFFFFFF) begin
         fail_hi_run <= fail_hi_run + 32'h1;
      end
   end

   property p_deglitch_run;
      @(posedge clk_in) disable iff (!reset_n_in)
      fail_filt |-> (fail_hi_run > 32'(DEGLITCH_COUNT));
   endproperty
   a_deglitch_run: assert property (p_deglitch_run)
      else $error("Fail filter high before deglitch time elapsed");

   property p_normal_pwm;
      @(posedge clk_in) disable iff (!reset_n_in)
      (mode == SSFS_NORMAL && power_supply_ok_in && ground_ok_in)
         |=> (power_channel_outputs_out == $past(pwm_channels_in));
   endproperty
   a_normal_pwm: assert property (p_normal_pwm)
      else $error("Channels not driven by PWM in Normal mode");

   property p_fail_entry;
      @(posedge clk_in) disable iff (!reset_n_in)
      (mode == SSFS_NORMAL && fail_filt && wake_in && !power_off)
         |=> fail_mode_out;
   endproperty
   a_fail_entry: assert property (p_fail_entry)
      else $error("Fail mode not entered on filtered fail input");

   property p_status7;
      @(posedge clk_in) disable iff (!reset_n_in)
      logic_supply_ok_in
         |=> (status7_out[STAT7_FAIL_INPUT_BIT] == $past(fail_pin_s));
   endproperty
   a_status7: assert property (p_status7)
      else $error("Status bit does not show the fail input level");

   property p_faults_kept;
      @(posedge clk_in) disable iff (!reset_n_in)
      (pwr_loss && !fault_clear_in && fault_events_in == '0)
         |=> $stable(faults);
   endproperty
   a_faults_kept: assert property (p_faults_kept)
      else $error("Faults changed during power supply loss");

   property p_clear_set;
      @(posedge clk_in) disable iff (!reset_n_in)
      (fault_clear_in && !power_off)
         |=> (faults == $past(fault_events_in));
   endproperty
   a_clear_set: assert property (p_clear_set)
      else $error("Fault clear did not let a new event win");

   c_fail_mode: cover property (@(posedge clk_in) mode == SSFS_FAIL);
   c_pwr_loss: cover property (@(posedge clk_in) pwr_loss && awake);
   c_wake_report: cover property (@(posedge clk_in) clk_pin_out);
   c_power_off: cover property (@(posedge clk_in) awake ##1 power_off);
   c_reset_woken: cover property (@(posedge clk_in) awake && woke_by_reset);

endmodule : ssfs_supervisor

// ---- verif/ssfs_mcu_model.sv ----
/*
 Controller model facing the supervisor: drives the reset, fail-mode and
 direct input pins, and plays the far end of the shared clock pin.
 Assumes the bench sets pin levels and the device reports through oe_n.
*/
`timescale 1ns/1ps
module ssfs_mcu_model (
   // Clock
   input wire logic clk_in,
   // Levels asked for by the bench
   input wire logic rst_lvl_in,
   input wire logic fail_lvl_in,
   input wire logic [3:0] dir_lvl_in,
   // Device side of the clock pin
   input wire logic clk_pin_drv_in,
   input wire logic clk_pin_oe_n_in,
   // Pins towards the device
   output logic rst_pin_out,
   output logic fail_pin_out,
   output logic [3:0] dir_pin_out,
   output logic clk_pin_out
);
   // ==========================================================
   // Pin drive
   logic mcu_clk = 1'b0;
   // Pins follow the bench levels at once; the bench already changes
   // them on the falling edge, and a second stage here would race it
   assign rst_pin_out = rst_lvl_in;
   assign fail_pin_out = fail_lvl_in;
   assign dir_pin_out = dir_lvl_in;
   always @(negedge clk_in) begin
      mcu_clk <= ~mcu_clk;
   end
   // Device output wins; else our own clock, changing every cycle
   assign clk_pin_out = clk_pin_oe_n_in ? mcu_clk : clk_pin_drv_in;
endmodule : ssfs_mcu_model

// ---- verif/test_supply_and_fail_mode_supervisor.sv ----
/*
 Self-checking bench for the supply and fail mode supervisor.
 Assumes a 100 MHz clock and a short deglitch count for simulation.
*/
`timescale 1ns/1ps
module test_supply_and_fail_mode_supervisor;
   import ssfs_pkg::*;
   localparam int DEG = 8;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic wake = 1'b0;
   logic pok = 1'b1;
   logic lok = 1'b1;
   logic gok = 1'b1;
   logic rst_lvl = 1'b0;
   logic fail_lvl = 1'b0;
   logic [3:0] dir_lvl = 4'h0;
   logic [4:0] pwm = 5'h15;
   logic spi_sw = 1'b0;
   logic [7:0] fev = 8'h00;
   logic fclr = 1'b0;
   logic rst_pin, fail_pin, clk_pin, ck_drv, ck_oe_n, sleep_m, fail_m;
   logic [3:0] dir_pin;
   logic [4:0] ch;
   logic ext, rd_en, wd, clr, ck_smp;
   logic [7:0] flt, st7;
   int err_total = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #5 clk_in = ~clk_in;
   ssfs_mcu_model ssfs_mcu_model_i (.clk_in(clk_in), .rst_lvl_in(rst_lvl),
      .fail_lvl_in(fail_lvl), .dir_lvl_in(dir_lvl), .clk_pin_drv_in(ck_drv),
      .clk_pin_oe_n_in(ck_oe_n), .rst_pin_out(rst_pin),
      .fail_pin_out(fail_pin), .dir_pin_out(dir_pin),
      .clk_pin_out(clk_pin));
   ssfs_supervisor #(.DEGLITCH_COUNT(DEG)) ssfs_supervisor_i (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .wake_in(wake),
      .power_supply_ok_in(pok), .logic_supply_ok_in(lok),
      .ground_ok_in(gok), .active_low_reset_pin_in(rst_pin),
      .fail_mode_pin_in(fail_pin), .direct_channel_inputs_in(dir_pin),
      .clk_pin_in(clk_pin), .pwm_channels_in(pwm),
      .spi_ext_switch_in(spi_sw), .fault_events_in(fev),
      .fault_clear_in(fclr), .power_channel_outputs_out(ch),
      .external_switch_control_out(ext), .clk_pin_out(ck_drv),
      .clk_pin_oe_n_out(ck_oe_n), .clk_pin_sampled_out(ck_smp),
      .spi_read_enable_out(rd_en), .spi_watchdog_timeout_out(wd),
      .registers_clear_out(clr), .fault_report_out(flt),
      .status7_out(st7), .fail_mode_out(fail_m),
      .sleep_mode_out(sleep_m));
   // ==========================================================
   // Shared helpers
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask : cyc
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask : chk
   task automatic give_verdict();
      $display("Checks %0d, errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   // Cut a hang short
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         give_verdict();
      end
   end
   // ==========================================================
   // Scenarios
   task automatic t_sleep();
      cyc(3);
      chk(sleep_m === 1'b1 && ch === 5'h00, "not asleep");
      chk(ck_oe_n === 1'b1, "clock pin driven asleep");
   endtask : t_sleep
   task automatic t_normal();
      wake = 1'b1;
      cyc(6);
      chk(sleep_m === 1'b0 && ch === pwm, "pwm not on channels");
      chk(ck_oe_n === 1'b0 && ck_drv === 1'b1, "no wake report");
      chk(rd_en === 1'b1 && st7[0] === 1'b0, "status wrong");
      chk(ck_smp === 1'b1, "clock pin level not sampled");
   endtask : t_normal
   task automatic t_faults();
      for (int i = 0; i < NUM_FAULTS; i++) begin
         fev = 8'h01 << i;
         cyc(1);
         fev = 8'h00;
         cyc(2);
         chk(flt[i] === 1'b1, "fault not latched");
      end
      fclr = 1'b1;
      fev = 8'h08;
      cyc(1);
      fclr = 1'b0;
      fev = 8'h00;
      cyc(2);
      chk(flt === 8'h08, "fault clear wrong");
   endtask : t_faults
   task automatic t_pwr_loss();
      pok = 1'b0;
      spi_sw = 1'b1;
      cyc(3);
      chk(ch === 5'h00 && flt === 8'h08, "loss handling");
      chk(ext === 1'b1, "ext switch off");
      spi_sw = 1'b0;
      wake = 1'b0;
      cyc(3);
      chk(ext === 1'b0, "ext switch on");
      wake = 1'b1;
      cyc(5);
      chk((ck_oe_n | ~ck_drv) === 1'b1, "wake shown in loss");
      pok = 1'b1;
      lok = 1'b0;
      cyc(3);
      chk(wd === 1'b1 && rd_en === 1'b0, "no watchdog timeout");
      lok = 1'b1;
      cyc(3);
   endtask : t_pwr_loss
   task automatic t_power_off();
      pok = 1'b0;
      lok = 1'b0;
      cyc(3);
      chk(clr === 1'b1 && ch === 5'h00 && ext === 1'b0, "not off");
      pok = 1'b1;
      lok = 1'b1;
      cyc(6);
      chk(flt === 8'h00 && ch === pwm, "state kept");
      gok = 1'b0;
      cyc(3);
      chk(ch === 5'h00, "channels on without ground");
      gok = 1'b1;
      cyc(3);
   endtask : t_power_off
   task automatic t_fail();
      int n;
      fail_lvl = 1'b1;
      cyc(DEG / 2);
      fail_lvl = 1'b0;
      cyc(DEG + 8);
      chk(fail_m === 1'b0, "short pulse accepted");
      fail_lvl = 1'b1;
      dir_lvl = 4'hA;
      n = 0;
      while (fail_m !== 1'b1 && n < DEG + 12) begin
         cyc(1);
         n++;
      end
      chk(n > DEG && fail_m === 1'b1, "fail entry timing");
      chk(st7[0] === 1'b1, "status bit");
      cyc(1);
      chk(ch === 5'h0A, "direct control");
      lok = 1'b0;
      dir_lvl = 4'h5;
      cyc(1);
      chk(ch === 5'h0A, "direct input not synchronised");
      cyc(4);
      chk(ch === 5'h05 && fail_m === 1'b1, "fail without vcc");
      lok = 1'b1;
      fail_lvl = 1'b0;
      cyc(DEG + 8);
      chk(fail_m === 1'b0 && ch === pwm, "no return");
   endtask : t_fail
   task automatic t_woken_by_reset();
      wake = 1'b0;
      rst_lvl = 1'b1;
      cyc(5);
      wake = 1'b1;
      cyc(6);
      chk(ck_oe_n === 1'b1, "clock pin driven");
      rst_lvl = 1'b0;
      cyc(4);
      chk(ck_oe_n === 1'b1, "reset-woken device reported wake");
      wake = 1'b0;
      cyc(2);
      wake = 1'b1;
      cyc(6);
      chk(ck_oe_n === 1'b0 && ck_drv === 1'b1, "wake not reported");
   endtask : t_woken_by_reset
   initial begin
      repeat (12) @(posedge clk_in);
      @(negedge clk_in);
      reset_n_in = 1'b1;
      t_sleep();
      t_normal();
      t_faults();
      t_pwr_loss();
      t_power_off();
      t_fail();
      t_woken_by_reset();
      give_verdict();
   end
endmodule : test_supply_and_fail_mode_supervisor
